// File: logic/lmnd_pkg.sv
// Package for the literal, multiply and negate datapath
package lmnd_pkg;
   // Opcode encodings: high bytes, negate's upper seven bits, whole no-operation word
   localparam logic [7:0] OPC_AND_LITERAL = 8'hB5;
   localparam logic [7:0] OPC_MUL_LITERAL = 8'hBC;
   localparam logic [7:0] OPC_MUL_FILE = 8'h34;
   localparam logic [6:0] OPC_NEGATE_HI7 = 7'h16;
   localparam logic [15:0] OPC_NOP = 16'h0000;
   // Field positions in the instruction word
   localparam int OPC_HI_MSB = 15;
   localparam int OPC_HI_LSB = 8;
   localparam int STORE_SEL_BIT = 8;
   // Reset values; working register all ones so an AND literal can load any byte
   localparam logic [7:0] WORKING_REG_RESET = 8'hFF;
   localparam logic [7:0] PROD_RESET = 8'h00;
   localparam logic [1:0] QUARTER_RESET = 2'h0;
   // Flag layout of the flag port
   localparam int FLAG_OVERFLOW = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_DIGIT_CARRY = 1;
   localparam int FLAG_C = 0;
   // Operation kinds
   typedef enum logic [2:0] {
      LMND_OP_NONE,
      LMND_OP_AND_LIT,
      LMND_OP_MUL_LIT,
      LMND_OP_MUL_FILE,
      LMND_OP_NEG
   } lmnd_op_t;
endpackage

// File: logic/lmnd_datapath.sv
// Literal AND, multiply, negate and no-operation execution datapath
//
// Overview of operation
// - AND-literal opcode B5: working register gets AND with literal; only zero flag changes.
// - Multiplies form an unsigned 8x8 product of working register and operand.
// - Product high byte to product-high register, low byte to product-low register.
// - Multiply leaves working register and file register unmodified.
// - Multiplies change no status flag.
// - Zero product is not signalled; zero flag keeps its value.
// - Multiply: decode Q1, read Q2, compute Q3, write both products Q4.
// - Negate opcode 0010 110s forms two's complement of working register.
// - Store-select clear: negated value to working register and memory.
// - Store-select set: negated value only to memory, working register kept.
// - Negate updates overflow, carry, digit-carry and zero flags.
`timescale 1ns/1ps
module lmnd_datapath (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Instruction from decoder, sampled at Q1
   input wire logic [15:0] instr_word_in,
   // File register read data, sampled at Q2
   input wire logic [7:0] file_rdata_in,
   // Current status flags from the core
   input wire logic [3:0] flags_in,
   // Quarter phase
   output logic [1:0] quarter_out,
   // Architectural registers
   output logic [7:0] working_register_out,
   output logic [7:0] product_high_byte_out,
   output logic [7:0] product_low_byte_out,
   // Data memory access
   output logic [7:0] file_addr_out,
   output logic file_rd_out,
   output logic file_we_out,
   output logic [7:0] file_wdata_out,
   // Status flag update
   output logic [3:0] flags_out,
   output logic [3:0] flags_we_out
);
   import lmnd_pkg::*;

   typedef struct packed {
      // Sequencing and decoded instruction
      logic [1:0] quarter;
      lmnd_op_t op;
      logic store_sel;
      logic [7:0] low_byte;
      // Values carried between quarters
      logic [7:0] operand;
      logic [15:0] result;
      logic [3:0] new_flags;
      // Registers the program sees
      logic [7:0] working_register;
      logic [7:0] product_high_byte;
      logic [7:0] product_low_byte;
      // Data memory port
      logic [7:0] file_addr;
      logic file_rd;
      logic file_we;
      logic [7:0] file_wdata;
      // Flag port
      logic [3:0] flags;
      logic [3:0] flags_we;
   } lmnd_state_t;

   lmnd_state_t st;
   lmnd_state_t next_st;
   logic [7:0] neg_val;
   logic [4:0] low_nib_sum;
   logic [8:0] full_sum;
   logic [7:0] opc_hi;
   logic is_and_lit;
   logic is_mul_lit;
   logic is_mul_file;
   logic is_negate;
   logic is_nop;
   logic [7:0] and_val;
   logic [15:0] product;
   logic neg_overflow;

   // Opcode high byte decode; negate ignores its store-select bit
   assign opc_hi = instr_word_in[OPC_HI_MSB:OPC_HI_LSB];
   assign is_and_lit = (opc_hi == OPC_AND_LITERAL);
   assign is_mul_lit = (opc_hi == OPC_MUL_LITERAL);
   assign is_mul_file = (opc_hi == OPC_MUL_FILE);
   assign is_negate = (opc_hi[7:1] == OPC_NEGATE_HI7);
   // Only the all-zero word is the true no-operation; other words are ignored alike
   assign is_nop = (instr_word_in == OPC_NOP);

   // AND value and full-width product of the latched operand
   assign and_val = st.working_register & st.operand;
   // Widened first so the high byte is not lost to an 8-bit context
   assign product = 16'(st.working_register) * 16'(st.operand);

   // Negate arithmetic as complement plus one, giving carries for flags
   assign full_sum = {1'b0, ~st.working_register} + 9'h001;
   assign low_nib_sum = {1'b0, ~st.working_register[3:0]} + 5'h01;
   assign neg_val = full_sum[7:0];
   // Overflow only for 0x80 input, which negates to 0x80 again
   assign neg_overflow = (st.working_register == 8'h80);

   // Quarter sequencer and datapath next state
   always_comb begin
      next_st = st;
      // Strobes are pulses: cleared each cycle unless set below
      next_st.quarter = st.quarter + 2'h1;
      next_st.file_rd = 1'b0;
      next_st.file_we = 1'b0;
      next_st.flags_we = 4'h0;
      unique case (st.quarter)
         2'h0: begin
            // Q1 decode; unknown words fall to no operation
            next_st.op = LMND_OP_NONE;
            next_st.store_sel = instr_word_in[STORE_SEL_BIT];
            next_st.low_byte = instr_word_in[7:0];
            next_st.file_addr = instr_word_in[7:0];
            if (is_and_lit) begin
               next_st.op = LMND_OP_AND_LIT;
            end else if (is_mul_lit) begin
               next_st.op = LMND_OP_MUL_LIT;
            end else if (is_mul_file) begin
               next_st.op = LMND_OP_MUL_FILE;
               // Raised now so the read strobe stands during the second quarter
               next_st.file_rd = 1'b1;
            end else if (is_negate) begin
               next_st.op = LMND_OP_NEG;
            end else if (is_nop) begin
               next_st.op = LMND_OP_NONE;
            end
         end
         2'h1: begin
            // Q2 operand read: literal or file data
            next_st.operand = (st.op == LMND_OP_MUL_FILE) ? file_rdata_in : st.low_byte;
         end
         2'h2: begin
            // Q3 compute
            next_st.new_flags = flags_in;
            unique case (st.op)
               LMND_OP_AND_LIT: begin
                  // Zero flag alone; the other bits keep the core's copy
                  next_st.result = {8'h00, and_val};
                  next_st.new_flags[FLAG_Z] = (and_val == 8'h00);
               end
               LMND_OP_MUL_LIT, LMND_OP_MUL_FILE: begin
                  next_st.result = product;
               end
               LMND_OP_NEG: begin
                  next_st.result = {8'h00, neg_val};
                  next_st.new_flags[FLAG_OVERFLOW] = neg_overflow;
                  next_st.new_flags[FLAG_C] = full_sum[8];
                  next_st.new_flags[FLAG_DIGIT_CARRY] = low_nib_sum[4];
                  next_st.new_flags[FLAG_Z] = (neg_val == 8'h00);
               end
               default: begin
                  // No operation: nothing computed, nothing written later
                  next_st.result = st.result;
               end
            endcase
         end
         2'h3: begin
            // Q4 write back to destination
            unique case (st.op)
               LMND_OP_AND_LIT: begin
                  next_st.working_register = st.result[7:0];
                  next_st.flags = st.new_flags;
                  next_st.flags_we = 4'h1 << FLAG_Z;
               end
               LMND_OP_MUL_LIT, LMND_OP_MUL_FILE: begin
                  // Flags and sources untouched: no overflow or carry possible
                  next_st.product_high_byte = st.result[15:8];
                  next_st.product_low_byte = st.result[7:0];
                  next_st.flags_we = 4'h0;
               end
               LMND_OP_NEG: begin
                  // Memory copy always written; store-select guards only the working register
                  next_st.file_we = 1'b1;
                  next_st.file_wdata = st.result[7:0];
                  if (!st.store_sel) begin
                     next_st.working_register = st.result[7:0];
                  end
                  next_st.flags = st.new_flags;
                  next_st.flags_we = 4'hF;
               end
               default: begin
                  next_st.flags_we = 4'h0;
               end
            endcase
         end
      endcase
   end

   // State register; synchronous reset
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         // Clearing everything also drops any pulse in flight
         st <= '0;
         st.quarter <= QUARTER_RESET;
         st.working_register <= WORKING_REG_RESET;
         st.product_high_byte <= PROD_RESET;
         st.product_low_byte <= PROD_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops, no logic behind them
   assign quarter_out = st.quarter;
   assign working_register_out = st.working_register;
   assign product_high_byte_out = st.product_high_byte;
   assign product_low_byte_out = st.product_low_byte;
   // Memory strobes are one-cycle pulses; address holds for the whole cycle
   assign file_addr_out = st.file_addr;
   assign file_rd_out = st.file_rd;
   assign file_we_out = st.file_we;
   assign file_wdata_out = st.file_wdata;
   // Flag enables pulse with their values in the cycle after write-back
   assign flags_out = st.flags;
   assign flags_we_out = st.flags_we;
endmodule

// File: tb/lmnd_datapath_asserts.sv
// Timing and side-effect properties of the datapath ports
`timescale 1ns/1ps
module lmnd_datapath_asserts (
   // Watched design ports
   input wire logic core_clk_in, sys_rst_in, file_rd_out, file_we_out,
   input wire logic [1:0] quarter_out,
   input wire logic [7:0] working_register_out, product_high_byte_out, product_low_byte_out,
   input wire logic [7:0] file_wdata_out,
   input wire logic [3:0] flags_we_out
);
   // One clock domain, so shared clocking and reset
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   wire [15:0] prod = {product_high_byte_out, product_low_byte_out};
   a_quarter_step: assert property (1 |=> quarter_out == 2'($past(quarter_out) + 2'h1))
      else $error("quarter out of step");
   a_work_mid: assert property (quarter_out != 2'h0 |-> $stable(working_register_out))
      else $error("working register moved mid cycle");
   a_prod_mid: assert property (quarter_out != 2'h0 |-> $stable(prod))
      else $error("product moved mid cycle");
   a_store_q0: assert property (file_we_out |->
      quarter_out == 2'h0 && flags_we_out == 4'hF)
      else $error("store pulse misplaced");
   a_read_q1: assert property (file_rd_out |-> quarter_out == 2'h1 && !file_we_out)
      else $error("read pulse misplaced");
   a_flag_q0: assert property (|flags_we_out |-> quarter_out == 2'h0)
      else $error("flag write misplaced");
   a_mul_quiet: assert property ($changed(prod) |->
      !flags_we_out && $stable(working_register_out))
      else $error("multiply side effect");
   a_neg_copies: assert property (file_we_out && $changed(working_register_out) |->
      working_register_out == file_wdata_out)
      else $error("negate copies differ");
   // Main scenarios reached
   c_store: cover property (file_we_out);
   c_read: cover property (file_rd_out);
   c_zero_only: cover property (flags_we_out == 4'h4);
endmodule
bind lmnd_datapath lmnd_datapath_asserts lmnd_datapath_asserts_inst (.core_clk_in, .sys_rst_in,
   .file_rd_out, .file_we_out, .quarter_out, .working_register_out, .product_high_byte_out,
   .product_low_byte_out, .file_wdata_out, .flags_we_out);

// File: tb/lmnd_core_model.sv
// Data memory and status flag holder of the surrounding core
`timescale 1ns/1ps
module lmnd_core_model (
   input wire logic clk_in, rd_in, we_in,
   input wire logic [7:0] addr_in, wdata_in,
   input wire logic [3:0] fl_in, fwe_in,
   output logic [7:0] rdata_out,
   output logic [3:0] flags_out
);
   logic [7:0] mem [256];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
      flags_out = 4'h0;
   end
   // Bus shows inverted junk outside a read, so stale data cannot pass
   assign rdata_out = rd_in ? mem[addr_in] : ~mem[addr_in];
   // Store and per-bit flag update
   always @(posedge clk_in) begin
      if (we_in) mem[addr_in] <= wdata_in;
      flags_out <= (flags_out & ~fwe_in) | (fl_in & fwe_in);
   end
endmodule

// File: tb/test_literal_and_multiply_negate_datapath.sv
// Random instruction stream checked against an integer model
`timescale 1ns/1ps
module test_literal_and_multiply_negate_datapath;
   import lmnd_pkg::*;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [15:0] instr = 16'h0000;
   logic rd, we;
   logic [1:0] q;
   logic [7:0] w, ph, pl, fa, wd, rdat;
   logic [3:0] fo, fwe, fl;
   int n_errors = 0, tests_run = 0, mw = 0, mp = 0;
   int mm [256];
   int unsigned rs = 32'h1EE0;
   always #20 core_clk_in = ~core_clk_in;
   lmnd_datapath lmnd_datapath_inst (.core_clk_in, .sys_rst_in, .instr_word_in(instr),
      .file_rdata_in(rdat), .flags_in(fl), .quarter_out(q), .working_register_out(w),
      .product_high_byte_out(ph), .product_low_byte_out(pl), .file_addr_out(fa),
      .file_rd_out(rd), .file_we_out(we), .file_wdata_out(wd), .flags_out(fo), .flags_we_out(fwe));
   lmnd_core_model lmnd_core_model_inst (.clk_in(core_clk_in), .rd_in(rd), .we_in(we),
      .addr_in(fa), .wdata_in(wd), .fl_in(fo), .fwe_in(fwe), .rdata_out(rdat), .flags_out(fl));
   function int unsigned xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task chk(string nm, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task final_report;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard, well past 200 instructions of 160 ns
   initial begin
      #100000;
      n_errors++;
      final_report;
   end
   // Op 0 and, 1/2 multiplies, 3/4 negate store-select, 5 nop, 6 unknown word
   initial begin
      int op, k, r, ef, eq;
      for (int i = 0; i < 256; i++) mm[i] = (i * 37 + 5) & 255;
      mw = WORKING_REG_RESET;
      repeat (8) @(negedge core_clk_in);
      sys_rst_in = 1'b0;
      for (int n = 0; n < 200; n++) begin
         op = xs() % 7;
         k = xs() & 255;
         // Segment starts load the working register; fixed words hit zero and overflow
         if (n % 16 == 0) op = 0;
         if (n < 2) begin
            op = 3 * n;
            k = 0;
         end
         if (n == 16) k = 128;
         if (n == 17) op = 4;
         instr = op == 0 ? {OPC_AND_LITERAL, 8'(k)} : op == 1 ? {OPC_MUL_LITERAL, 8'(k)} :
            op == 2 ? {OPC_MUL_FILE, 8'(k)} : op < 5 ? {OPC_NEGATE_HI7, op == 4, 8'(k)} :
            op == 5 ? OPC_NOP : {8'hFF, 8'(k)};
         eq = 0;
         ef = 0;
         r = 0;
         case (op)
            0: begin
               mw &= k;
               eq = 1 << FLAG_Z;
               ef = int'(mw == 0) << FLAG_Z;
            end
            1: mp = mw * k;
            2: mp = mw * mm[k];
            3, 4: begin
               r = (256 - mw) & 255;
               mm[k] = r;
               eq = 15;
               ef = (int'(mw == 128) << FLAG_OVERFLOW) | (int'(r == 0) << FLAG_Z);
               ef |= (int'((mw & 15) == 0) << FLAG_DIGIT_CARRY) | (int'(mw == 0) << FLAG_C);
               if (op == 3) mw = r;
            end
            default: ;
         endcase
         repeat (4) @(posedge core_clk_in);
         @(negedge core_clk_in);
         chk("working_register", 16'(mw), {8'h00, w});
         chk("product", 16'(mp), {ph, pl});
         chk("store", 16'(op == 3 || op == 4 ? 256 + r : 0), {7'h00, we, wd & {8{we}}});
         chk("store_addr", 16'(op == 3 || op == 4 ? k : 0), {8'h00, fa & {8{we}}});
         chk("flags", 16'(eq * 16 + ef), {8'h00, fwe, fo & fwe});
         chk("quarter", 16'h0000, {14'h0000, q});
         if (n % 16 == 15) begin
            // Mid-run reset, two cycles so no half-reset state reaches the checks
            sys_rst_in = 1'b1;
            repeat (2) @(negedge core_clk_in);
            sys_rst_in = 1'b0;
            mw = WORKING_REG_RESET;
            mp = {PROD_RESET, PROD_RESET};
         end
      end
      final_report;
   end
endmodule
